// ---- design/array_mode_drive.sv ----
/*
  Registered drive of the flash array operating mode and the erase
  block enables. Assumes its inputs are already interlocked by the
  register logic; runs on hclk with asynchronous active-low reset.
*/
`timescale 1ns/1ns
module array_mode_drive (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       prog_bit,
  input  wire logic       erase_bit,
  input  wire logic       pverify_bit,
  input  wire logic       everify_bit,
  input  wire logic [6:0] block_bits,
  input  wire logic       boot_mode,
  output logic            program_mode,
  output logic            erase_mode,
  output logic            program_verify_mode,
  output logic            erase_verify_mode,
  output logic [6:0]      erase_block_enable,
  output logic            erase_whole_array
);

  typedef struct packed {
    logic       prog;
    logic       erase;
    logic       pverify;
    logic       everify;
    logic [6:0] blocks;
    logic       whole;
  } drive_t;

  drive_t q;
  drive_t d;

  always_comb begin
    d         = q;
    d.prog    = prog_bit;
    d.erase   = erase_bit;
    d.pverify = pverify_bit;
    d.everify = everify_bit;
    // serial boot erases everything, blocks only matter in user mode
    d.whole   = boot_mode;
    d.blocks  = boot_mode ? flash_ctrl_pkg::ALL_BLOCKS : block_bits;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // erased cells read as all ones; the array itself handles that
  assign program_mode        = q.prog;
  assign erase_mode          = q.erase;
  assign program_verify_mode = q.pverify;
  assign erase_verify_mode   = q.everify;
  assign erase_block_enable  = q.blocks;
  assign erase_whole_array   = q.whole;

endmodule : array_mode_drive

// ---- design/flash_ctrl_pkg.sv ----
/*
  Constants, register indices and field positions for the flash
  program/erase control block and its array mode driver.
  Assumes byte registers on a 32-bit AHB-Lite bus, one word each,
  byte address = index * 4.
*/
package flash_ctrl_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_MODE_ONE   = 16'hff80;
  localparam logic [15:0] IDX_MODE_TWO   = 16'hff81;
  localparam logic [15:0] IDX_BLOCK_SEL  = 16'hff83;
  localparam logic [15:0] IDX_PIN_MON    = 16'hff89;
  localparam logic [15:0] IDX_SYS_CTL3   = 16'hff8f;

  // flash_mode_control_one fields
  localparam int MC1_PIN_WE_BIT  = 7;
  localparam int MC1_SW_WE_BIT   = 6;
  localparam int MC1_EVERIFY_BIT = 3;
  localparam int MC1_PVERIFY_BIT = 2;
  localparam int MC1_ERASE_BIT   = 1;
  localparam int MC1_PROG_BIT    = 0;

  // flash_mode_control_two fields
  localparam int MC2_ESETUP_BIT  = 1;
  localparam int MC2_PSETUP_BIT  = 0;

  // system_control_three field
  localparam int SYS3_SELECT_BIT = 3;

  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] ERASED_BYTE    = 8'hff;
  localparam int         BLOCK_COUNT    = 7;
  localparam logic [6:0] ALL_BLOCKS     = 7'h7f;
  localparam logic [15:0] ARRAY_LAST    = 16'hedff;

  // block sizes in kbytes, block zero first
  localparam int BLOCK_KB_0 = 1;
  localparam int BLOCK_KB_4 = 28;
  localparam int BLOCK_KB_5 = 16;
  localparam int BLOCK_KB_6 = 12;

  // each register access takes two states: one wait state
  localparam int ACCESS_STATES = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_WAIT = 1'b1
  } bus_phase_t;

endpackage : flash_ctrl_pkg

// ---- design/flash_program_erase_control.sv ----
/*
  Flash program/erase control registers behind an AHB-Lite slave.
  Assumes a single master, single word transfers, hclk at 20 MHz,
  pin inputs synchronous to hclk, asynchronous active-low reset.
*/
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ns
// Notes on behaviour
// - flash registers decoded only while select set
// - byte registers, each access takes two states
// - pin enable low ignores all flash writes
// - mode one reads 80 or 00 after reset
// - mode two, block select cleared when protected
// - no-flash build reads zero, ignores writes
// - bit seven mirrors the pin enable level
// - software enable writable only with pin high
// - verify bits need pin and software enable
// - erase bit also needs erase setup
// - program bit also needs program setup
// - bits five and four read zero
// - seven erase blocks of given sizes
// - boot mode erases the whole array
// - one block select bit per erase block
// - setup bits need both enables, cleared protected
// - clearing select keeps register contents
// - monitor shows two mode pin levels
module flash_program_erase_control #(
  parameter bit FLASH_FITTED = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        pin_write_enable,
  input  wire logic        mode_pin_one,
  input  wire logic        mode_pin_two,
  input  wire logic        standby,
  output logic             program_mode,
  output logic             erase_mode,
  output logic             program_verify_mode,
  output logic             erase_verify_mode,
  output logic [6:0]       erase_block_enable,
  output logic             erase_whole_array
);

  typedef struct packed {
    flash_ctrl_pkg::bus_phase_t phase;
    logic        wr;
    logic        addr_ok;
    logic [15:0] idx;
    logic        ready;
    logic [31:0] rdata;
    logic        pin;
    logic [1:0]  mon;
    logic        sel;
    logic        software_write_enable;
    logic        ev;
    logic        pv;
    logic        er;
    logic        pg;
    logic        erase_setup_bit;
    logic        program_setup_bit;
    logic [6:0]  erase_block_select;
  } state_t;

  state_t q;
  state_t d;

  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic       flash_sel;

  assign wbyte     = hwdata[7:0];
  assign flash_sel = q.sel && FLASH_FITTED;

  always_comb begin
    d     = q;
    rbyte = flash_ctrl_pkg::RST_BYTE;
    d.pin = pin_write_enable;
    d.mon = {mode_pin_two, mode_pin_one};
    unique case (q.phase)
      flash_ctrl_pkg::PH_IDLE: begin
        d.ready = 1'b1;
        if (hsel && hready && htrans == flash_ctrl_pkg::HTRANS_NONSEQ) begin
          // one wait state gives the two-state access
          d.phase   = flash_ctrl_pkg::PH_WAIT;
          d.ready   = 1'b0;
          d.wr      = hwrite;
          d.idx     = haddr[17:2];
          d.addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
        end
      end
      flash_ctrl_pkg::PH_WAIT: begin
        d.phase = flash_ctrl_pkg::PH_IDLE;
        d.ready = 1'b1;
        if (q.addr_ok && q.wr && FLASH_FITTED) begin
          unique case (q.idx)
            flash_ctrl_pkg::IDX_MODE_ONE: begin
              if (flash_sel && pin_write_enable) begin
                d.software_write_enable = wbyte[flash_ctrl_pkg::MC1_SW_WE_BIT];
                if (q.software_write_enable) begin
                  d.ev = wbyte[flash_ctrl_pkg::MC1_EVERIFY_BIT];
                  d.pv = wbyte[flash_ctrl_pkg::MC1_PVERIFY_BIT];
                end
                if (q.software_write_enable && q.erase_setup_bit) begin
                  d.er = wbyte[flash_ctrl_pkg::MC1_ERASE_BIT];
                end
                if (q.software_write_enable && q.program_setup_bit) begin
                  d.pg = wbyte[flash_ctrl_pkg::MC1_PROG_BIT];
                end
              end
            end
            flash_ctrl_pkg::IDX_MODE_TWO: begin
              if (flash_sel && pin_write_enable && q.software_write_enable) begin
                d.erase_setup_bit = wbyte[flash_ctrl_pkg::MC2_ESETUP_BIT];
                d.program_setup_bit = wbyte[flash_ctrl_pkg::MC2_PSETUP_BIT];
              end
            end
            flash_ctrl_pkg::IDX_BLOCK_SEL: begin
              if (flash_sel && pin_write_enable && q.software_write_enable) begin
                d.erase_block_select = wbyte[6:0];
              end
            end
            flash_ctrl_pkg::IDX_SYS_CTL3: begin
              d.sel = wbyte[flash_ctrl_pkg::SYS3_SELECT_BIT];
            end
            default: begin
            end
          endcase
        end else if (q.addr_ok && !q.wr && FLASH_FITTED) begin
          unique case (q.idx)
            flash_ctrl_pkg::IDX_MODE_ONE: begin
              if (flash_sel) begin
                rbyte[flash_ctrl_pkg::MC1_PIN_WE_BIT]  = q.pin;
                rbyte[flash_ctrl_pkg::MC1_SW_WE_BIT]   = q.software_write_enable;
                rbyte[flash_ctrl_pkg::MC1_EVERIFY_BIT] = q.ev;
                rbyte[flash_ctrl_pkg::MC1_PVERIFY_BIT] = q.pv;
                rbyte[flash_ctrl_pkg::MC1_ERASE_BIT]   = q.er;
                rbyte[flash_ctrl_pkg::MC1_PROG_BIT]    = q.pg;
                // bits five and four stay zero
              end
            end
            flash_ctrl_pkg::IDX_MODE_TWO: begin
              if (flash_sel) begin
                rbyte[flash_ctrl_pkg::MC2_ESETUP_BIT] = q.erase_setup_bit;
                rbyte[flash_ctrl_pkg::MC2_PSETUP_BIT] = q.program_setup_bit;
              end
            end
            flash_ctrl_pkg::IDX_BLOCK_SEL: begin
              if (flash_sel) begin
                rbyte = {1'b0, q.erase_block_select};
              end
            end
            flash_ctrl_pkg::IDX_PIN_MON: begin
              rbyte = {6'h00, q.mon};
            end
            flash_ctrl_pkg::IDX_SYS_CTL3: begin
              rbyte[flash_ctrl_pkg::SYS3_SELECT_BIT] = q.sel;
            end
            default: begin
            end
          endcase
        end
        // unfitted build answers zero everywhere, monitor included
        d.rdata = {24'h000000, rbyte};
      end
      default: begin
        d.phase = flash_ctrl_pkg::PH_IDLE;
      end
    endcase

    // protection forcing wins over any write in the same cycle
    if (standby) begin
      d.software_write_enable = 1'b0;
      d.ev  = 1'b0;
      d.pv  = 1'b0;
      d.er  = 1'b0;
      d.pg  = 1'b0;
      d.erase_setup_bit = 1'b0;
      d.program_setup_bit = 1'b0;
      d.erase_block_select = 7'h00;
    end
    if (!pin_write_enable) begin
      d.software_write_enable = 1'b0;
      d.ev  = 1'b0;
      d.pv  = 1'b0;
      d.er  = 1'b0;
      d.pg  = 1'b0;
    end
    if (!pin_write_enable || !d.software_write_enable) begin
      d.erase_setup_bit = 1'b0;
      d.program_setup_bit = 1'b0;
      d.erase_block_select = 7'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q       <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hrdata    = q.rdata;
  assign hreadyout = q.ready;
  assign hresp     = 1'b0;

  // serial boot is selected by both mode pins low
  array_mode_drive u_drive (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .prog_bit            (q.pg),
    .erase_bit           (q.er),
    .pverify_bit         (q.pv),
    .everify_bit         (q.ev),
    .block_bits          (q.erase_block_select),
    .boot_mode           (q.mon == 2'h0),
    .program_mode        (program_mode),
    .erase_mode          (erase_mode),
    .program_verify_mode (program_verify_mode),
    .erase_verify_mode   (erase_verify_mode),
    .erase_block_enable  (erase_block_enable),
    .erase_whole_array   (erase_whole_array)
  );

endmodule : flash_program_erase_control

// ---- test/flash_ctrl_chk.sv ----
/*
  Port checker for the flash program/erase control block.
  Assumes one hclk domain, async active-low reset, a single bus master.
*/
`timescale 1ns/1ns
module flash_ctrl_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pin_write_enable,
  input wire logic        mode_pin_one,
  input wire logic        mode_pin_two,
  input wire logic        standby,
  input wire logic        program_mode,
  input wire logic        erase_mode,
  input wire logic        program_verify_mode,
  input wire logic        erase_verify_mode,
  input wire logic [6:0]  erase_block_enable,
  input wire logic        erase_whole_array
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic taken = hsel && hready && htrans == flash_ctrl_pkg::HTRANS_NONSEQ;
  wire logic quiet = !program_mode && !erase_mode && !program_verify_mode
                     && !erase_verify_mode;
  wire logic boot  = !mode_pin_one && !mode_pin_two;
  AST_OKAY_ONLY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_ONE_WAIT: assert property (taken |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take one wait state");
  AST_WAIT_CAUSED: assert property (!hreadyout |-> $past(taken))
    else $error("wait state without a transfer");
  AST_PIN_LOW_QUIET: assert property (!pin_write_enable [*4] |-> quiet)
    else $error("array mode active with write pin low");
  AST_STANDBY_QUIET: assert property (standby [*4] |-> quiet)
    else $error("array mode active in standby");
  AST_BOOT_WHOLE: assert property (boot [*3] |-> erase_whole_array
    && erase_block_enable == flash_ctrl_pkg::ALL_BLOCKS)
    else $error("boot mode not erasing whole array");
  AST_PROG_PIN: assert property ($rose(program_mode) |-> $past(pin_write_enable, 2))
    else $error("program mode entered with pin low");
  AST_ERASE_PIN: assert property ($rose(erase_mode) |-> $past(pin_write_enable, 2))
    else $error("erase mode entered with pin low");
  cover property (taken);
  cover property (program_mode);
  cover property (erase_mode);
endmodule : flash_ctrl_chk

bind flash_program_erase_control flash_ctrl_chk flash_ctrl_chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready), .htrans(htrans),
  .hreadyout(hreadyout), .hresp(hresp), .pin_write_enable(pin_write_enable),
  .mode_pin_one(mode_pin_one), .mode_pin_two(mode_pin_two), .standby(standby),
  .program_mode(program_mode), .erase_mode(erase_mode),
  .program_verify_mode(program_verify_mode), .erase_verify_mode(erase_verify_mode),
  .erase_block_enable(erase_block_enable), .erase_whole_array(erase_whole_array));

// ---- test/flash_program_erase_control_tb.sv ----
/*
  Self-checking bench for the flash control block: table of register
  accesses, then pin, standby, boot and reset cases.
  Assumes the AHB master is the only party; flash-less build runs beside.
*/
`timescale 1ns/1ns
module flash_program_erase_control_tb;
  localparam logic [15:0] M1 = flash_ctrl_pkg::IDX_MODE_ONE;
  localparam logic [15:0] M2 = flash_ctrl_pkg::IDX_MODE_TWO;
  localparam logic [15:0] EB = flash_ctrl_pkg::IDX_BLOCK_SEL;
  localparam logic [15:0] MON = flash_ctrl_pkg::IDX_PIN_MON;
  localparam logic [15:0] S3 = flash_ctrl_pkg::IDX_SYS_CTL3;
  localparam logic R = 1'b0;
  localparam logic W = 1'b1;
  typedef struct packed {
    logic [15:0] idx;
    logic        wr;
    logic [7:0]  dat;
  } row_t;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        pin_write_enable = 1'b1, mode_pin_one = 1'b0, mode_pin_two = 1'b1;
  logic        standby = 1'b0, hreadyout, hresp, hreadyout_nf, erase_whole_array;
  logic        program_mode, erase_mode, program_verify_mode, erase_verify_mode;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [6:0]  erase_block_enable;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hrdata_nf, rd, rd_nf;
  int          mismatches = 0, n_compared = 0;
  // rows: write data, or the value a read must return
  row_t rows [40] = '{
    '{S3, R, 8'h00}, '{M1, R, 8'h00}, '{M1, W, 8'h40}, '{S3, W, 8'hff},
    '{S3, R, 8'h08}, '{M1, R, 8'h80}, '{M2, R, 8'h00}, '{M2, W, 8'h01},
    '{M2, R, 8'h00}, '{M1, W, 8'h04}, '{M1, R, 8'h80}, '{M1, W, 8'h40},
    '{M1, R, 8'hc0}, '{M1, W, 8'h70}, '{M1, R, 8'hc0}, '{M1, W, 8'h41},
    '{M1, W, 8'h42}, '{M1, R, 8'hc0}, '{M1, W, 8'h44}, '{M1, R, 8'hc4},
    '{M1, W, 8'h40}, '{M2, W, 8'h01}, '{M2, R, 8'h01}, '{M1, W, 8'h41},
    '{M1, R, 8'hc1}, '{M1, W, 8'h40}, '{M2, W, 8'h00}, '{M2, W, 8'h02},
    '{M1, W, 8'h42}, '{M1, R, 8'hc2}, '{EB, W, 8'h01}, '{EB, R, 8'h01},
    '{EB, W, 8'h82}, '{EB, R, 8'h02}, '{MON, R, 8'h02}, '{16'hff82, R, 8'h00},
    '{S3, W, 8'h00}, '{M1, R, 8'h00}, '{S3, W, 8'h08}, '{M1, R, 8'hc2}};

  always #25 hclk = ~hclk;

  flash_program_erase_control flash_program_erase_control_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_write_enable(pin_write_enable), .mode_pin_one(mode_pin_one),
    .mode_pin_two(mode_pin_two), .standby(standby), .program_mode(program_mode),
    .erase_mode(erase_mode), .program_verify_mode(program_verify_mode),
    .erase_verify_mode(erase_verify_mode), .erase_block_enable(erase_block_enable),
    .erase_whole_array(erase_whole_array));

  // flash-less build on the same bus, shadowing every access
  flash_program_erase_control #(.FLASH_FITTED(1'b0)) flash_program_erase_control_nf_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata_nf), .hreadyout(hreadyout_nf), .hresp(),
    .pin_write_enable(pin_write_enable), .mode_pin_one(mode_pin_one),
    .mode_pin_two(mode_pin_two), .standby(standby), .program_mode(),
    .erase_mode(), .program_verify_mode(), .erase_verify_mode(),
    .erase_block_enable(), .erase_whole_array());

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= flash_ctrl_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    rd_nf = hrdata_nf;
  endtask : xfer

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
    xfer(R, idx, 8'h00);
    check(rd, {24'h0, e});
    check(rd_nf, 32'h0);
    check({31'h0, hreadyout_nf}, 32'h1);
  endtask : rd_chk

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // armed before any mode bit is set, so a stuck sequence cannot hang the run
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr)
        xfer(W, rows[i].idx, rows[i].dat);
      else
        rd_chk(rows[i].idx, rows[i].dat);
    end
    check({30'h0, erase_mode, program_mode}, 32'h2);
    pin_write_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    check({31'h0, erase_mode}, 32'h0);
    xfer(W, M1, 8'h40);
    rd_chk(M1, 8'h00);
    rd_chk(M2, 8'h00);
    rd_chk(EB, 8'h00);
    pin_write_enable <= 1'b1;
    xfer(W, M1, 8'h40);
    rd_chk(M1, 8'hc0);
    standby <= 1'b1;
    repeat (5) @(posedge hclk);
    standby <= 1'b0;
    rd_chk(M1, 8'h80);
    mode_pin_two <= 1'b0;
    repeat (4) @(posedge hclk);
    check({24'h0, erase_whole_array, erase_block_enable}, 32'hff);
    rd_chk(MON, 8'h00);
    // second reset with the pin low must leave bit seven clear
    pin_write_enable <= 1'b0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset cleared the select bit; reopen the window before looking at bit seven
    xfer(W, S3, 8'h08);
    rd_chk(M1, 8'h00);
    give_verdict();
  end
endmodule : flash_program_erase_control_tb
